// [logic/ec_host_pkg.sv]
// Constants shared by the embedded controller host interface files.
package ec_host_pkg;
    // -------------------------------------------------------------------
    // Host I/O ports of the two decode ranges
    // -------------------------------------------------------------------
    localparam int NUM_CH = 2;
    localparam logic [15:0] DATA_PORT [NUM_CH] = '{16'h0060, 16'h0062};
    localparam logic [15:0] CMD_PORT [NUM_CH] = '{16'h0064, 16'h0066};

    // -------------------------------------------------------------------
    // Status byte bit positions
    // -------------------------------------------------------------------
    localparam int ST_OUT_FULL = 0;
    localparam int ST_IN_FULL = 1;
    localparam int ST_CMD = 3;
    localparam int ST_BURST = 4;
    localparam int ST_NOTIFY = 5;
    localparam int ST_MGMT = 6;

    // -------------------------------------------------------------------
    // Firmware register offsets
    // -------------------------------------------------------------------
    localparam logic [8:0] CH_STRIDE = 9'h004;
    localparam logic [8:0] SUB_IN = 9'h000;
    localparam logic [8:0] SUB_OUT = 9'h001;
    localparam logic [8:0] SUB_STAT = 9'h002;
    localparam logic [8:0] R_IRQ_STAT = 9'h008;
    localparam logic [8:0] R_IRQ_MASK = 9'h009;
    localparam int SPACE_SEL = 8;
    localparam int SPACE_SIZE = 256;

    // -------------------------------------------------------------------
    // Controller interrupt events and reset values
    // -------------------------------------------------------------------
    localparam int EVT_W = 5;
    localparam int EV_WROTE0 = 0;
    localparam int EV_TOOK0 = 1;
    localparam int EV_WROTE1 = 2;
    localparam int EV_TOOK1 = 3;
    localparam int EV_REFUSED = 4;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] EVT_RST = 5'h00;
endpackage

// [logic/host_port_channel.sv]
// One host decode range: data byte, command/status byte and flags.
`timescale 1ns/1ps
module host_port_channel #(
    parameter bit SHARED = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_host_data_wr,
    input wire logic i_host_cmd_wr,
    input wire logic i_host_data_rd,
    input wire logic [7:0] i_host_wdata,
    input wire logic i_fw_in_rd,
    input wire logic i_fw_out_wr,
    input wire logic i_fw_ctl_wr,
    input wire logic [7:0] i_fw_wdata,
    output logic [7:0] o_in_byte,
    output logic [7:0] o_out_byte,
    output logic [7:0] o_status,
    output logic o_host_wrote,
    output logic o_host_took,
    output logic o_refused
);
    logic [7:0] in_r, in_nxt, out_r, out_nxt;
    logic output_full_flag_r, output_full_flag_nxt, input_full_flag_r, input_full_flag_nxt;
    logic cmd_r, cmd_nxt;
    logic burst_r, burst_nxt, notify_r, notify_nxt, mgmt_r, mgmt_nxt;
    logic req_r, req_nxt, host_wr, load_ok;

    always_comb begin
        host_wr = i_host_data_wr | i_host_cmd_wr;
        // A shared range only takes a reply once a host party has asked.
        load_ok = i_fw_out_wr & (~SHARED | req_r);
        in_nxt = in_r;
        out_nxt = out_r;
        output_full_flag_nxt = output_full_flag_r;
        input_full_flag_nxt = input_full_flag_r;
        cmd_nxt = cmd_r;
        req_nxt = req_r;
        burst_nxt = burst_r;
        notify_nxt = notify_r;
        mgmt_nxt = mgmt_r;
        // Clears are applied first so a same-cycle set wins.
        if (i_fw_in_rd) begin
            input_full_flag_nxt = 1'b0;
        end
        if (i_host_data_rd) begin
            output_full_flag_nxt = 1'b0;
        end
        if (load_ok) begin
            out_nxt = i_fw_wdata;
            output_full_flag_nxt = 1'b1;
            req_nxt = 1'b0;
        end
        if (host_wr) begin
            in_nxt = i_host_wdata;
            input_full_flag_nxt = 1'b1;
            cmd_nxt = i_host_cmd_wr;
            req_nxt = 1'b1;
        end
        if (i_fw_ctl_wr) begin
            burst_nxt = i_fw_wdata[ec_host_pkg::ST_BURST];
            notify_nxt = i_fw_wdata[ec_host_pkg::ST_NOTIFY];
            mgmt_nxt = i_fw_wdata[ec_host_pkg::ST_MGMT];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            in_r <= ec_host_pkg::BYTE_RST;
            out_r <= ec_host_pkg::BYTE_RST;
            output_full_flag_r <= 1'b0;
            input_full_flag_r <= 1'b0;
            cmd_r <= 1'b0;
            req_r <= 1'b0;
            burst_r <= 1'b0;
            notify_r <= 1'b0;
            mgmt_r <= 1'b0;
        end else begin
            in_r <= in_nxt;
            out_r <= out_nxt;
            output_full_flag_r <= output_full_flag_nxt;
            input_full_flag_r <= input_full_flag_nxt;
            cmd_r <= cmd_nxt;
            req_r <= req_nxt;
            burst_r <= burst_nxt;
            notify_r <= notify_nxt;
            mgmt_r <= mgmt_nxt;
        end
    end

    always_comb begin
        o_status = 8'h00;
        o_status[ec_host_pkg::ST_OUT_FULL] = output_full_flag_r;
        o_status[ec_host_pkg::ST_IN_FULL] = input_full_flag_r;
        o_status[ec_host_pkg::ST_CMD] = cmd_r;
        o_status[ec_host_pkg::ST_BURST] = burst_r;
        o_status[ec_host_pkg::ST_NOTIFY] = notify_r;
        o_status[ec_host_pkg::ST_MGMT] = mgmt_r;
        o_in_byte = in_r;
        o_out_byte = out_r;
        o_host_wrote = host_wr;
        o_host_took = i_host_data_rd & output_full_flag_r;
        o_refused = i_fw_out_wr & ~load_ok;
    end
endmodule

// [logic/event_irq.sv]
// Sticky event status, mask and level interrupt for the controller side.
`timescale 1ns/1ps
module event_irq (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [4:0] i_evt,
    input wire logic i_stat_rd,
    input wire logic i_mask_wr,
    input wire logic [4:0] i_mask_wdata,
    output logic [4:0] o_status,
    output logic [4:0] o_mask,
    output logic o_irq
);
    logic [4:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        // A read clears, but an event in the same cycle is kept.
        stat_nxt = (i_stat_rd ? 5'h00 : stat_r) | i_evt;
        mask_nxt = i_mask_wr ? i_mask_wdata : mask_r;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stat_r <= ec_host_pkg::EVT_RST;
            mask_r <= ec_host_pkg::EVT_RST;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_status = stat_r;
    assign o_mask = mask_r;
    assign o_irq = irq_r;
endmodule

// [logic/ec_host_if.sv]
// Embedded controller host interface: two host ranges, firmware port, 256-byte space.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ec_host_if (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_notify,
    output logic o_host_mgmt,
    input wire logic [8:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_irq
);
    // -------------------------------------------------------------------
    // Decoding helpers
    // -------------------------------------------------------------------
    function automatic logic fw_hit(input logic [8:0] addr, input int ch,
                                    input logic [8:0] sub);
        logic [8:0] base;
        base = 9'(ch) * ec_host_pkg::CH_STRIDE;
        fw_hit = (addr == (base + sub));
    endfunction

    function automatic logic host_hit(input logic [15:0] addr,
                                      input logic [15:0] port);
        host_hit = (addr == port);
    endfunction

    // -------------------------------------------------------------------
    // Host ranges
    // -------------------------------------------------------------------
    logic [7:0] in_byte [ec_host_pkg::NUM_CH];
    logic [7:0] out_byte [ec_host_pkg::NUM_CH];
    logic [7:0] status [ec_host_pkg::NUM_CH];
    logic [ec_host_pkg::NUM_CH-1:0] h_data_wr, h_cmd_wr, h_data_rd, h_cmd_rd;
    logic [ec_host_pkg::NUM_CH-1:0] f_in_rd, f_out_wr, f_ctl_wr;
    logic [ec_host_pkg::NUM_CH-1:0] wrote, took, refused;

    genvar g;
    generate
        for (g = 0; g < ec_host_pkg::NUM_CH; g++) begin : g_ch
            // Byte-wide strobes: one access moves exactly one byte.
            assign h_data_wr[g] = i_host_wr &
                host_hit(i_host_addr, ec_host_pkg::DATA_PORT[g]);
            assign h_cmd_wr[g] = i_host_wr &
                host_hit(i_host_addr, ec_host_pkg::CMD_PORT[g]);
            assign h_data_rd[g] = i_host_rd &
                host_hit(i_host_addr, ec_host_pkg::DATA_PORT[g]);
            assign h_cmd_rd[g] = i_host_rd &
                host_hit(i_host_addr, ec_host_pkg::CMD_PORT[g]);
            assign f_in_rd[g] = i_reg_rd & fw_hit(i_reg_addr, g, ec_host_pkg::SUB_IN);
            assign f_out_wr[g] = i_reg_wr & fw_hit(i_reg_addr, g, ec_host_pkg::SUB_OUT);
            assign f_ctl_wr[g] = i_reg_wr & fw_hit(i_reg_addr, g, ec_host_pkg::SUB_STAT);

            // Range 0 is shared under the host's lock; range 1 is private.
            host_port_channel #(
                .SHARED(g == 0)
            ) u_ch (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_host_data_wr(h_data_wr[g]),
                .i_host_cmd_wr(h_cmd_wr[g]),
                .i_host_data_rd(h_data_rd[g]),
                .i_host_wdata(i_host_wdata),
                .i_fw_in_rd(f_in_rd[g]),
                .i_fw_out_wr(f_out_wr[g]),
                .i_fw_ctl_wr(f_ctl_wr[g]),
                .i_fw_wdata(i_reg_wdata),
                .o_in_byte(in_byte[g]),
                .o_out_byte(out_byte[g]),
                .o_status(status[g]),
                .o_host_wrote(wrote[g]),
                .o_host_took(took[g]),
                .o_refused(refused[g])
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // Host read data and host attention outputs
    // -------------------------------------------------------------------
    logic [7:0] host_rdata_r, host_rdata_nxt;
    logic notify_r, notify_nxt, mgmt_r, mgmt_nxt;

    always_comb begin
        host_rdata_nxt = host_rdata_r;
        notify_nxt = 1'b0;
        mgmt_nxt = 1'b0;
        if (i_host_rd) begin
            host_rdata_nxt = 8'h00;
        end
        for (int c = 0; c < ec_host_pkg::NUM_CH; c++) begin
            if (h_data_rd[c]) begin
                host_rdata_nxt = out_byte[c];
            end
            if (h_cmd_rd[c]) begin
                host_rdata_nxt = status[c];
            end
            // The interface's own host interrupt, separate from any keyboard logic.
            notify_nxt = notify_nxt | status[c][ec_host_pkg::ST_NOTIFY];
            mgmt_nxt = mgmt_nxt | status[c][ec_host_pkg::ST_MGMT];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            host_rdata_r <= ec_host_pkg::BYTE_RST;
            notify_r <= 1'b0;
            mgmt_r <= 1'b0;
        end else begin
            host_rdata_r <= host_rdata_nxt;
            notify_r <= notify_nxt;
            mgmt_r <= mgmt_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Controller interrupt
    // -------------------------------------------------------------------
    logic [ec_host_pkg::EVT_W-1:0] evt, irq_status, irq_mask;
    logic irq_stat_rd, irq_mask_wr, irq_line;

    always_comb begin
        evt = '0;
        // Host port writes, host data reads while output-full is set, and refused firmware replies, signal the controller firmware.
        evt[ec_host_pkg::EV_WROTE0] = wrote[0];
        evt[ec_host_pkg::EV_TOOK0] = took[0];
        evt[ec_host_pkg::EV_WROTE1] = wrote[1];
        evt[ec_host_pkg::EV_TOOK1] = took[1];
        evt[ec_host_pkg::EV_REFUSED] = |refused;
    end

    assign irq_stat_rd = i_reg_rd & (i_reg_addr == ec_host_pkg::R_IRQ_STAT);
    assign irq_mask_wr = i_reg_wr & (i_reg_addr == ec_host_pkg::R_IRQ_MASK);

    event_irq u_irq (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_evt(evt),
        .i_stat_rd(irq_stat_rd),
        .i_mask_wr(irq_mask_wr),
        .i_mask_wdata(i_reg_wdata[ec_host_pkg::EVT_W-1:0]),
        .o_status(irq_status),
        .o_mask(irq_mask),
        .o_irq(irq_line)
    );

    // -------------------------------------------------------------------
    // Controller address space
    // -------------------------------------------------------------------
    // No reset on the array: it is plain storage and firmware initialises it.
    logic [7:0] space_mem [ec_host_pkg::SPACE_SIZE];
    logic space_wr;

    assign space_wr = i_reg_wr & i_reg_addr[ec_host_pkg::SPACE_SEL];

    always_ff @(posedge i_clk) begin
        if (space_wr) begin
            space_mem[i_reg_addr[7:0]] <= i_reg_wdata;
        end
    end

    // -------------------------------------------------------------------
    // Firmware read data
    // -------------------------------------------------------------------
    logic [7:0] reg_rdata_r, reg_rdata_nxt;
    logic irq_r;

    always_comb begin
        reg_rdata_nxt = reg_rdata_r;
        if (i_reg_rd) begin
            reg_rdata_nxt = 8'h00;
            if (i_reg_addr[ec_host_pkg::SPACE_SEL]) begin
                reg_rdata_nxt = space_mem[i_reg_addr[7:0]];
            end else if (i_reg_addr == ec_host_pkg::R_IRQ_STAT) begin
                reg_rdata_nxt = {3'h0, irq_status};
            end else if (i_reg_addr == ec_host_pkg::R_IRQ_MASK) begin
                reg_rdata_nxt = {3'h0, irq_mask};
            end
            for (int c = 0; c < ec_host_pkg::NUM_CH; c++) begin
                if (fw_hit(i_reg_addr, c, ec_host_pkg::SUB_IN)) begin
                    reg_rdata_nxt = in_byte[c];
                end
                if (fw_hit(i_reg_addr, c, ec_host_pkg::SUB_OUT)) begin
                    reg_rdata_nxt = out_byte[c];
                end
                if (fw_hit(i_reg_addr, c, ec_host_pkg::SUB_STAT)) begin
                    reg_rdata_nxt = status[c];
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_rdata_r <= ec_host_pkg::BYTE_RST;
            irq_r <= 1'b0;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
            irq_r <= irq_line;
        end
    end

    assign o_host_rdata = host_rdata_r;
    assign o_host_notify = notify_r;
    assign o_host_mgmt = mgmt_r;
    assign o_reg_rdata = reg_rdata_r;
    assign o_irq = irq_r;
endmodule

// [tb/ec_host_if_props.sv]
// Concurrent checks on the ports of the embedded controller host interface.
`timescale 1ns/1ps
module ec_host_if_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_wdata,
    input wire logic [7:0] o_host_rdata,
    input wire logic o_host_notify,
    input wire logic o_host_mgmt,
    input wire logic [8:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic cw0;
    logic dw0;
    logic dr0;
    logic sr0;
    logic gap;
    logic mw;
    assign cw0 = i_host_wr && (i_host_addr == 16'h0064);
    assign dw0 = i_host_wr && (i_host_addr == 16'h0060);
    assign dr0 = i_host_rd && (i_host_addr == 16'h0060);
    assign sr0 = i_host_rd && (i_host_addr == 16'h0064);
    assign gap = !i_host_wr && !i_host_rd && !i_reg_rd && !i_reg_wr;
    assign mw = i_reg_wr && (i_reg_addr == 9'h009);
    // ---------------------------------------------------------------
    // Host visible flags and the controller interrupt
    // ---------------------------------------------------------------
    sequence s_cmd_stat;
        cw0 && !i_reg_rd ##1 gap ##1 sr0;
    endsequence
    sequence s_data_stat;
        dw0 && !i_reg_rd ##1 gap ##1 sr0;
    endsequence
    AST_CMD_FLAGS: assert property (s_cmd_stat |=> o_host_rdata[1] && o_host_rdata[3])
        else $error("command write did not set input-full and command flags");
    AST_DATA_FLAGS: assert property (s_data_stat |=> o_host_rdata[1] && !o_host_rdata[3])
        else $error("data write flags wrong");
    AST_OUT_FULL_CLR: assert property (dr0 && !i_reg_wr ##1 gap ##1 sr0 |=> !o_host_rdata[0])
        else $error("output-full not cleared by host data read");
    AST_OUT_FULL_SET: assert property (i_reg_wr && i_reg_addr == 9'h005 ##1 gap ##1
        i_host_rd && i_host_addr == 16'h0066 |=> o_host_rdata[0])
        else $error("reply load did not set output-full");
    AST_IN_FULL_CLR: assert property (i_reg_rd && i_reg_addr == 9'h000 && !i_host_wr ##1 gap ##1
        sr0 |=> !o_host_rdata[1])
        else $error("input-full not cleared by firmware read");
    AST_IGN_BITS: assert property (sr0 |=> !o_host_rdata[7] && !o_host_rdata[2])
        else $error("ignored status bits not zero");
    AST_UNMAPPED: assert property (i_host_rd && !(i_host_addr inside {16'h0060, 16'h0062,
        16'h0064, 16'h0066}) |=> o_host_rdata == 8'h00)
        else $error("unmapped host read not zero");
    AST_HOLD: assert property (!i_host_rd |=> $stable(o_host_rdata))
        else $error("host read data moved without a read");
    AST_NOTIFY: assert property (i_reg_wr && i_reg_addr == 9'h002 && i_reg_wdata[5]
        |-> ##[1:3] o_host_notify)
        else $error("notify event not raised");
    AST_IRQ_MASK: assert property (mw && i_reg_wdata[4:0] == 5'h00 ##1 !mw [*3] |-> !o_irq)
        else $error("interrupt high with all events masked");
endmodule
bind ec_host_if ec_host_if_props chk (.i_clk(i_clk), .i_rst(i_rst), .i_host_addr(i_host_addr),
    .i_host_wr(i_host_wr), .i_host_rd(i_host_rd), .i_host_wdata(i_host_wdata),
    .o_host_rdata(o_host_rdata), .o_host_notify(o_host_notify), .o_host_mgmt(o_host_mgmt),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));

// [tb/host_cpu_model.sv]
// Host processor model that drives the host I/O port of the controller.
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [15:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    logic lock_held;
    initial begin
        o_addr = 16'hffff;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
        lock_held = 1'b0;
    end
    // The shared range is touched only while the global lock is held.
    task automatic take_lock(input logic [15:0] a);
        lock_held = (a == 16'h0060) || (a == 16'h0064);
    endtask
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        take_lock(a);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // A released bus shows the inverse so stale values cannot pass.
        o_addr <= ~a;
        o_wdata <= ~d;
        lock_held = 1'b0;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        take_lock(a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
        lock_held = 1'b0;
    endtask
endmodule

// [tb/ec_host_if_test.sv]
// Self-checking testbench of the embedded controller host interface.
`timescale 1ns/1ps
module ec_host_if_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] h_addr;
    logic h_wr;
    logic h_rd;
    logic [7:0] h_wdata;
    logic [7:0] h_rdata;
    logic notify;
    logic mgmt;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    int n_errors = 0;
    int checks = 0;
    always #4 i_clk = ~i_clk;
    ec_host_if dut (.i_clk(i_clk), .i_rst(i_rst), .i_host_addr(h_addr), .i_host_wr(h_wr),
        .i_host_rd(h_rd), .i_host_wdata(h_wdata), .o_host_rdata(h_rdata),
        .o_host_notify(notify), .o_host_mgmt(mgmt), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_irq(irq));
    host_cpu_model host (.i_clk(i_clk), .i_rdata(h_rdata), .o_addr(h_addr), .o_wr(h_wr),
        .o_rd(h_rd), .o_wdata(h_wdata));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic r_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rc(input logic [8:0] a, input logic [7:0] e);
        @(posedge i_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task automatic hc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.io_rd(a, v);
        check(v, e);
    endtask
    // The interrupt and event outputs lag their cause by two registers.
    task automatic pins(input logic [7:0] e);
        repeat (3) @(posedge i_clk);
        #1 check({5'h00, irq, mgmt, notify}, e);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        hc(16'h0064, 8'h00);
        hc(16'h0066, 8'h00);
        rc(9'h009, 8'h00);
        pins(8'h00);
        $display("test reset done");
    endtask
    task automatic t_cmd();
        host.io_wr(16'h0064, 8'h80);
        hc(16'h0064, 8'h0a);
        rc(9'h000, 8'h80);
        hc(16'h0064, 8'h08);
        host.io_wr(16'h0060, 8'h11);
        hc(16'h0064, 8'h02);
        rc(9'h000, 8'h11);
        $display("test command done");
    endtask
    task automatic t_reply();
        r_wr(9'h001, 8'h55);
        hc(16'h0064, 8'h01);
        hc(16'h0060, 8'h55);
        hc(16'h0064, 8'h00);
        $display("test reply done");
    endtask
    task automatic t_refuse();
        rc(9'h008, 8'h03);
        r_wr(9'h001, 8'h66);
        hc(16'h0064, 8'h00);
        rc(9'h008, 8'h10);
        host.io_wr(16'h0060, 8'h22);
        r_wr(9'h001, 8'h77);
        hc(16'h0064, 8'h03);
        hc(16'h0060, 8'h77);
        rc(9'h000, 8'h22);
        $display("test refuse done");
    endtask
    task automatic t_private();
        rc(9'h008, 8'h03);
        r_wr(9'h005, 8'ha5);
        hc(16'h0066, 8'h01);
        hc(16'h0062, 8'ha5);
        host.io_wr(16'h0066, 8'h84);
        hc(16'h0066, 8'h0a);
        hc(16'h0064, 8'h00);
        rc(9'h004, 8'h84);
        rc(9'h008, 8'h0c);
        $display("test private done");
    endtask
    task automatic t_irq();
        r_wr(9'h009, 8'h01);
        rc(9'h009, 8'h01);
        host.io_wr(16'h0060, 8'h33);
        pins(8'h04);
        r_wr(9'h009, 8'h00);
        pins(8'h00);
        r_wr(9'h009, 8'h01);
        pins(8'h04);
        rc(9'h008, 8'h01);
        pins(8'h00);
        rc(9'h000, 8'h33);
        $display("test interrupt done");
    endtask
    task automatic t_events();
        r_wr(9'h002, 8'h70);
        pins(8'h03);
        hc(16'h0064, 8'h70);
        r_wr(9'h002, 8'h00);
        pins(8'h00);
        $display("test events done");
    endtask
    task automatic t_space();
        r_wr(9'h100, 8'ha5);
        r_wr(9'h1ff, 8'h5a);
        rc(9'h100, 8'ha5);
        rc(9'h1ff, 8'h5a);
        r_wr(9'h00a, 8'hff);
        rc(9'h00a, 8'h00);
        host.io_wr(16'h0061, 8'h99);
        hc(16'h0061, 8'h00);
        hc(16'h0064, 8'h00);
        $display("test space done");
    endtask
    task automatic t_rerst();
        host.io_wr(16'h0064, 8'h81);
        r_wr(9'h005, 8'h12);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        hc(16'h0064, 8'h00);
        hc(16'h0066, 8'h00);
        $display("test second reset done");
    endtask
    initial begin
        repeat (4000) @(posedge i_clk);
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_cmd();
        t_reply();
        t_refuse();
        t_private();
        t_irq();
        t_events();
        t_space();
        t_rerst();
        end_sim();
    end
endmodule
